// ---- hw/pfa_pkg.sv ----
// constants, types and shared functions of the parameter flash block access logic
package pfa_pkg;

    // ********************************
    // geometry
    // ********************************
    localparam int unsigned BLK_BYTES = 32;
    localparam int unsigned N_SLOTS   = 7;
    localparam int unsigned SLOT_W    = 3;

    // ********************************
    // command codes
    // ********************************
    localparam logic [7:0] CMD_CTRL_LO   = 8'h00;
    localparam logic [7:0] CMD_CTRL_HI   = 8'h01;
    localparam logic [7:0] CMD_FLAGS_LO  = 8'h0E;
    localparam logic [7:0] CMD_FLAGS_HI  = 8'h0F;
    localparam logic [7:0] CMD_CLASS     = 8'h3E;
    localparam logic [7:0] CMD_BLOCK     = 8'h3F;
    localparam logic [7:0] CMD_WIN_FIRST = 8'h40;
    localparam logic [7:0] CMD_WIN_LAST  = 8'h5F;
    localparam logic [7:0] CMD_CSUM      = 8'h60;
    localparam logic [7:0] CMD_BDC       = 8'h61;

    // ********************************
    // field values and reset values
    // ********************************
    localparam logic [7:0]  BDC_CLASS_MODE = 8'h00;
    localparam logic [7:0]  BDC_RST        = 8'h01;
    localparam logic [7:0]  SEL_RST        = 8'h00;
    localparam logic [7:0]  INFO_A_SEL     = 8'h01;
    localparam logic [7:0]  INFO_C_SEL     = 8'h03;
    localparam logic [7:0]  SUB_INFO       = 8'h3A;
    localparam logic [7:0]  SUB_DATA       = 8'h30;
    localparam logic [7:0]  SUB_REGS       = 8'h40;
    localparam logic [7:0]  SUB_KEYS       = 8'h70;
    localparam logic [7:0]  CSUM_BASE      = 8'hFF;
    localparam logic [15:0] SUBCMD_SEAL    = 16'h0020;
    localparam logic [15:0] SUBCMD_LOADER  = 16'h0F00;
    localparam int unsigned CS_SS_BIT      = 13;
    localparam int unsigned FLAGS_FAS_BIT  = 14;
    localparam int unsigned MDATE_OFS      = 2;
    localparam int unsigned DATE_YEAR_BASE = 1980;
    localparam int unsigned DATE_MONTH_MUL = 32;
    localparam int unsigned DATE_YEAR_MUL  = 256;
    // stored keys as read back: unlock 0, unlock 1, privileged 0, privileged 1
    localparam logic [3:0][15:0] KEY_RST = {16'h4444, 16'h3333, 16'h2222, 16'h1111};

    // ********************************
    // slots of the flash array
    // ********************************
    localparam logic [SLOT_W-1:0] SLOT_INFO_A = 3'h0;
    localparam logic [SLOT_W-1:0] SLOT_INFO_C = 3'h2;
    localparam logic [SLOT_W-1:0] SLOT_KEYS   = 3'h3;
    localparam logic [SLOT_W-1:0] SLOT_DATA0  = 3'h4;
    localparam logic [SLOT_W-1:0] SLOT_REGS   = 3'h6;

    // ********************************
    // types
    // ********************************
    typedef enum logic [1:0] {MODE_SEALED, MODE_UNLOCKED_MODE, MODE_FULL, MODE_LOADER} pfa_mode_t;
    typedef enum logic [1:0] {PEND_NONE, PEND_UNSEAL, PEND_FULL} pfa_pend_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pfa_req_t;

    typedef struct packed {
        logic commit;
        logic reject;
    } pfa_evt_t;

    typedef struct packed {
        logic [4:0]  day;
        logic [3:0]  month;
        logic [15:0] year;
    } pfa_date_t;

    // ********************************
    // functions
    // ********************************
    function automatic logic [15:0] pfa_swap16(input logic [15:0] w);
        return {w[7:0], w[15:8]};
    endfunction : pfa_swap16

    function automatic logic [15:0] pfa_date_code(input pfa_date_t d);
        int unsigned v;
        v = d.day + d.month * DATE_MONTH_MUL + (d.year - DATE_YEAR_BASE) * DATE_YEAR_MUL;
        return v[15:0];
    endfunction : pfa_date_code

endpackage : pfa_pkg

// ---- hw/pfa_block_access.sv ----
// parameter flash block window, checksum commit and key-based security modes

// Summary of operation
// - holds a 32-byte user information area in flash, host readable and writable
// - unlocked with access control 0x00: info area reached like any location
// - flash written from the window only after a correct checksum arrives
// - class access: subclass 58, offsets 0 to 31, is the info area
// - locations resolved by subclass id and offset, no grouping class needed
// - locked or control not 0x00: index 1..3 loads info block A..C
// - info selection mode: edited window stored back after a valid checksum
// - locked: info block A readable but never committed
// - privileged read/write all; unlocked read all, write all but keys; locked read public only; loader none
// - loader entry and key rewrite only from privileged mode
// - key pair must come as two consecutive control words, else rejected
// - sealed flag set while locked, cleared by the unlock key pair
// - full-access flag cleared by the privileged key pair
// - keys stored as two-byte words, rewritable only in privileged mode
// - control key words compared byte-swapped against stored words
// - manufacture date stored as day + month*32 + (year-1980)*256
// - expected checksum is 255 minus byte sum of window 0x40..0x5F
// - command 0x61 is block access control; 0x00 enables class access
// - command 0x3F is block index; index n maps offsets 32n..32n+31
module pfa_block_access
    import pfa_pkg::*;
(
    // clock and reset
    input  wire logic      i_ref_clk,
    input  wire logic      i_rstn,
    // host command port
    input  wire pfa_req_t  i_req,
    output logic [7:0]     o_rdata,
    // manufacture date stamp
    input  wire logic      i_date_wr,
    input  wire pfa_date_t i_date,
    // state
    output pfa_mode_t      o_mode,
    output logic           o_sealed_flag,
    output logic           o_full_access_flag,
    output pfa_evt_t       o_evt
);

    // ********************************
    // storage
    // ********************************
    logic [BLK_BYTES-1:0][7:0] flash_mem [N_SLOTS];
    logic [BLK_BYTES-1:0][7:0] win_reg;
    logic [7:0]                class_reg;
    logic [7:0]                blk_reg;
    logic [7:0]                bdc_reg;
    logic [7:0]                ctrl_lo_reg;
    pfa_mode_t                 mode_reg;
    pfa_pend_t                 pend_reg;

    logic              class_mode;
    logic              sel_ok;
    logic [SLOT_W-1:0] sel_slot;
    logic              next_ok;
    logic [SLOT_W-1:0] next_slot;
    logic              rd_ok;
    logic              wr_ok;
    logic [7:0]        csum_exp;
    logic              csum_wr;
    logic              commit;
    logic              reload;
    logic              win_wr;
    logic [4:0]        win_idx;
    logic              ctrl_evt;
    logic [15:0]       ctrl_word;
    logic [15:0]       key_sw;
    logic [15:0]       cs_word;
    logic [15:0]       flags_word;
    logic [15:0]       date_code;

    // ********************************
    // helpers
    // ********************************
    // access mode, subclass id and index pick the slot; grouping class is never looked at
    function automatic logic [SLOT_W:0] slot_map(input logic cm, input logic [7:0] cls, input logic [7:0] blk);
        logic [SLOT_W:0] r;
        r = '0;
        if (!cm) begin
            if (blk >= INFO_A_SEL && blk <= INFO_C_SEL) begin
                r = {1'b1, SLOT_W'(blk - INFO_A_SEL)};
            end
        end else if (cls == SUB_INFO && blk == SEL_RST) begin
            r = {1'b1, SLOT_INFO_A};
        end else if (cls == SUB_KEYS && blk == SEL_RST) begin
            r = {1'b1, SLOT_KEYS};
        end else if (cls == SUB_DATA && blk <= INFO_A_SEL) begin
            r = {1'b1, SLOT_W'(SLOT_DATA0 + blk[SLOT_W-1:0])};
        end else if (cls == SUB_REGS && blk == SEL_RST) begin
            r = {1'b1, SLOT_REGS};
        end
        return r;
    endfunction : slot_map

    function automatic logic [15:0] key_word(input logic [BLK_BYTES-1:0][7:0] b, input int k);
        return {b[2*k], b[2*k+1]};
    endfunction : key_word

    function automatic logic [7:0] byte_sum(input logic [BLK_BYTES-1:0][7:0] b);
        logic [7:0] s;
        s = '0;
        for (int i = 0; i < BLK_BYTES; i++) begin
            s = s + b[i];
        end
        return s;
    endfunction : byte_sum

    // ********************************
    // decode
    // ********************************
    assign class_mode = (mode_reg == MODE_UNLOCKED_MODE || mode_reg == MODE_FULL)
                        && bdc_reg == BDC_CLASS_MODE;
    assign {sel_ok, sel_slot} = slot_map(class_mode, class_reg, blk_reg);
    assign {next_ok, next_slot} = slot_map(class_mode,
        (i_req.wr && i_req.addr == CMD_CLASS) ? i_req.wdata : class_reg,
        (i_req.wr && i_req.addr == CMD_BLOCK) ? i_req.wdata : blk_reg);

    assign reload   = i_req.wr && (i_req.addr == CMD_CLASS || i_req.addr == CMD_BLOCK);
    assign win_wr   = i_req.wr && i_req.addr >= CMD_WIN_FIRST && i_req.addr <= CMD_WIN_LAST
                      && mode_reg != MODE_LOADER;
    assign win_idx  = 5'(i_req.addr - CMD_WIN_FIRST);
    assign csum_exp = CSUM_BASE - byte_sum(win_reg);
    assign csum_wr  = i_req.wr && i_req.addr == CMD_CSUM;
    assign date_code = pfa_date_code(i_date);

    // reads: loader sees nothing; locked never reaches a private slot
    assign rd_ok = sel_ok && mode_reg != MODE_LOADER;

    always_comb begin
        wr_ok = 1'b0;
        unique case (mode_reg)
            MODE_SEALED:   wr_ok = sel_slot != SLOT_INFO_A;
            MODE_UNLOCKED_MODE: wr_ok = sel_slot != SLOT_KEYS;
            MODE_FULL:     wr_ok = 1'b1;
            MODE_LOADER:   wr_ok = 1'b0;
        endcase
    end

    // a mismatch simply drops the commit; the window stays for a retry
    assign commit = csum_wr && i_req.wdata == csum_exp && sel_ok && wr_ok;

    assign ctrl_evt  = i_req.wr && i_req.addr == CMD_CTRL_HI;
    assign ctrl_word = {i_req.wdata, ctrl_lo_reg};
    assign key_sw    = pfa_swap16(ctrl_word);

    always_comb begin
        cs_word = '0;
        cs_word[CS_SS_BIT] = o_sealed_flag;
        flags_word = '0;
        flags_word[FLAGS_FAS_BIT] = o_full_access_flag;
    end

    // ********************************
    // parameter flash
    // ********************************
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int s = 0; s < N_SLOTS; s++) begin
                flash_mem[s] <= '0;
            end
            for (int k = 0; k < 4; k++) begin
                flash_mem[SLOT_KEYS][2*k]   <= KEY_RST[k][15:8];
                flash_mem[SLOT_KEYS][2*k+1] <= KEY_RST[k][7:0];
            end
        end else begin
            if (commit) begin
                flash_mem[sel_slot] <= win_reg;
            end
            // a stamp in the same cycle as a commit to this slot overrides those two bytes
            if (i_date_wr) begin
                flash_mem[SLOT_DATA0][MDATE_OFS]   <= date_code[15:8];
                flash_mem[SLOT_DATA0][MDATE_OFS+1] <= date_code[7:0];
            end
        end
    end

    // ********************************
    // window
    // ********************************
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            win_reg <= '0;
        end else if (reload) begin
            win_reg <= next_ok ? flash_mem[next_slot] : '0;
        end else if (win_wr) begin
            win_reg[win_idx] <= i_req.wdata;
        end
    end

    // ********************************
    // selection registers
    // ********************************
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            class_reg <= SEL_RST;
            blk_reg   <= SEL_RST;
            bdc_reg   <= BDC_RST;
        end else if (i_req.wr) begin
            if (i_req.addr == CMD_CLASS) begin
                class_reg <= i_req.wdata;
            end
            if (i_req.addr == CMD_BLOCK) begin
                blk_reg <= i_req.wdata;
            end
            if (i_req.addr == CMD_BDC) begin
                bdc_reg <= i_req.wdata;
            end
        end
    end

    // ********************************
    // security modes
    // ********************************
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_lo_reg <= '0;
        end else if (i_req.wr && i_req.addr == CMD_CTRL_LO) begin
            ctrl_lo_reg <= i_req.wdata;
        end
    end

    // any control word that is not the expected second key drops the pending first key
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mode_reg <= MODE_SEALED;
            pend_reg <= PEND_NONE;
        end else if (ctrl_evt) begin
            pend_reg <= PEND_NONE;
            if (pend_reg == PEND_UNSEAL && mode_reg == MODE_SEALED
                && key_sw == key_word(flash_mem[SLOT_KEYS], 1)) begin
                mode_reg <= MODE_UNLOCKED_MODE;
            end else if (pend_reg == PEND_FULL && mode_reg == MODE_UNLOCKED_MODE
                && key_sw == key_word(flash_mem[SLOT_KEYS], 3)) begin
                mode_reg <= MODE_FULL;
            end else if (mode_reg == MODE_SEALED && key_sw == key_word(flash_mem[SLOT_KEYS], 0)) begin
                pend_reg <= PEND_UNSEAL;
            end else if (mode_reg == MODE_UNLOCKED_MODE && key_sw == key_word(flash_mem[SLOT_KEYS], 2)) begin
                pend_reg <= PEND_FULL;
            end else if (ctrl_word == SUBCMD_SEAL
                && (mode_reg == MODE_UNLOCKED_MODE || mode_reg == MODE_FULL)) begin
                mode_reg <= MODE_SEALED;
            end else if (ctrl_word == SUBCMD_LOADER && mode_reg == MODE_FULL) begin
                mode_reg <= MODE_LOADER;
            end
        end
    end

    assign o_mode             = mode_reg;
    assign o_sealed_flag      = mode_reg == MODE_SEALED;
    assign o_full_access_flag = mode_reg != MODE_FULL;

    // ********************************
    // read data and events
    // ********************************
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= '0;
            if (i_req.rd) begin
                if (i_req.addr >= CMD_WIN_FIRST && i_req.addr <= CMD_WIN_LAST) begin
                    o_rdata <= rd_ok ? win_reg[win_idx] : '0;
                end else begin
                    unique case (i_req.addr)
                        CMD_CTRL_LO:  o_rdata <= cs_word[7:0];
                        CMD_CTRL_HI:  o_rdata <= cs_word[15:8];
                        CMD_FLAGS_LO: o_rdata <= flags_word[7:0];
                        CMD_FLAGS_HI: o_rdata <= flags_word[15:8];
                        CMD_CLASS:    o_rdata <= class_reg;
                        CMD_BLOCK:    o_rdata <= blk_reg;
                        CMD_BDC:      o_rdata <= bdc_reg;
                        CMD_CSUM:     o_rdata <= rd_ok ? csum_exp : '0;
                        default:      o_rdata <= '0;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_evt <= '0;
        end else begin
            o_evt.commit <= commit;
            o_evt.reject <= csum_wr && !commit;
        end
    end

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_first_unlock_key;
        ctrl_evt && mode_reg == MODE_SEALED && key_sw == key_word(flash_mem[SLOT_KEYS], 0);
    endsequence

    sequence s_wrong_second_key;
        ctrl_evt && key_sw != key_word(flash_mem[SLOT_KEYS], 1);
    endsequence

    a_bad_sum_holds: assert property (
        csum_wr && i_req.wdata != csum_exp |=> o_evt.reject && !o_evt.commit && $stable(win_reg))
        else $error("bad checksum changed state or was not rejected");

    a_good_sum_commits: assert property (
        csum_wr && i_req.wdata == csum_exp && sel_ok && wr_ok && !i_date_wr
        |=> o_evt.commit && flash_mem[$past(sel_slot)] == $past(win_reg))
        else $error("valid checksum did not store the window");

    a_info_a_locked: assert property (
        csum_wr && mode_reg == MODE_SEALED && sel_slot == SLOT_INFO_A |=> !o_evt.commit)
        else $error("info block A committed while locked");

    a_loader_no_read: assert property (
        i_req.rd && mode_reg == MODE_LOADER && i_req.addr >= CMD_WIN_FIRST && i_req.addr <= CMD_WIN_LAST
        |=> o_rdata == 8'h00)
        else $error("window readable in loader mode");

    a_interrupted_pair: assert property (
        s_first_unlock_key ##1 (!ctrl_evt) [*3] ##1 s_wrong_second_key |=> mode_reg == MODE_SEALED)
        else $error("interrupted key pair unlocked the device");

    a_unlock_clears_ss: assert property (
        ctrl_evt && pend_reg == PEND_UNSEAL && mode_reg == MODE_SEALED
        && key_sw == key_word(flash_mem[SLOT_KEYS], 1) |=> !o_sealed_flag ##1 mode_reg == MODE_UNLOCKED_MODE)
        else $error("unlock key pair did not clear the sealed flag");

    a_full_clears_fas: assert property (
        ctrl_evt && pend_reg == PEND_FULL && mode_reg == MODE_UNLOCKED_MODE
        && key_sw == key_word(flash_mem[SLOT_KEYS], 3) |=> !o_full_access_flag)
        else $error("privileged key pair did not clear the full-access flag");

    a_loader_from_full: assert property (
        ctrl_evt && ctrl_word == SUBCMD_LOADER && mode_reg != MODE_FULL
        && mode_reg != MODE_LOADER |=> mode_reg != MODE_LOADER)
        else $error("loader mode entered from a lower mode");

    a_keys_full_only: assert property (
        csum_wr && sel_slot == SLOT_KEYS && mode_reg != MODE_FULL |=> !o_evt.commit)
        else $error("keys rewritten outside privileged mode");

    a_info_class_map: assert property (
        class_mode && i_req.wr && i_req.addr == CMD_CLASS && i_req.wdata == SUB_INFO
        && blk_reg == SEL_RST |=> win_reg == $past(flash_mem[SLOT_INFO_A]))
        else $error("subclass 58 did not load the info area");

    a_info_sel_window: assert property (
        !class_mode && i_req.wr && i_req.addr == CMD_BLOCK && i_req.wdata == INFO_C_SEL
        |=> win_reg == $past(flash_mem[SLOT_INFO_C]))
        else $error("index 3 did not load info block C");

    a_sum_readback: assert property (
        i_req.rd && i_req.addr == CMD_CSUM && rd_ok |=> o_rdata == $past(csum_exp))
        else $error("checksum readback differs from expected value");

endmodule : pfa_block_access

// ---- verification/pfa_host_model.sv ----
// host side model: drives single-cycle command writes and reads toward the block
module pfa_host_model
    import pfa_pkg::*;
(
    // clock
    input  wire logic       i_ref_clk,
    // command port toward the block
    output pfa_req_t        o_req,
    input  wire logic [7:0] i_rdata
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        o_req = '0;
    end

    // ********************************
    // bus cycles
    // ********************************
    // strobe is dropped after the taking edge; the #1 keeps a following call off that edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        o_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_ref_clk);
        o_req.wr <= 1'b0;
        #1;
    endtask : wr

    // read data stand only in the cycle after the strobe, so they are taken then
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_ref_clk);
        o_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_ref_clk);
        o_req.rd <= 1'b0;
        #1;
        d = i_rdata;
    endtask : rd

    // key words go out byte-swapped against their readback, low byte first, high byte next
    task automatic key(input logic [15:0] k);
        wr(CMD_CTRL_LO, k[15:8]);
        wr(CMD_CTRL_HI, k[7:0]);
    endtask : key
endmodule : pfa_host_model

// ---- verification/testbench.sv ----
// self-checking testbench of the block window, checksum commit and security modes
module testbench import pfa_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic       i_ref_clk;
    logic       i_rstn;
    logic       i_date_wr;
    pfa_date_t  i_date;
    pfa_req_t   req;
    logic [7:0] rdata;
    pfa_mode_t  mode;
    logic       sealed;
    logic       full_access_flag;
    pfa_evt_t   evt;
    int         fails;
    int         check_count;
    int         cycles;
    logic [7:0] d;

    pfa_block_access pfa_block_access_inst (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_req(req), .o_rdata(rdata),
        .i_date_wr(i_date_wr), .i_date(i_date), .o_mode(mode), .o_sealed_flag(sealed),
        .o_full_access_flag(full_access_flag), .o_evt(evt));
    pfa_host_model pfa_host_model_inst (.i_ref_clk(i_ref_clk), .o_req(req), .i_rdata(rdata));

    // ********************************
    // helpers
    // ********************************
    task automatic end_of_test();
        if (fails == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        pfa_host_model_inst.wr(a, v);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        pfa_host_model_inst.rd(a, d);
        chk($sformatf("read at %h", a), {8'h00, exp}, {8'h00, d});
    endtask : rdc

    // one pulse shows the outcome of a checksum write, never both
    task automatic csum(input logic [7:0] v, input logic ok);
        wr(CMD_CSUM, v);
        chk("commit pulse", {15'h0, ok}, {15'h0, evt.commit});
        chk("reject pulse", {15'h0, !ok}, {15'h0, evt.reject});
    endtask : csum

    task automatic ctl(input logic [15:0] w);
        wr(CMD_CTRL_LO, w[7:0]);
        wr(CMD_CTRL_HI, w[15:8]);
    endtask : ctl

    task automatic state(input pfa_mode_t m, input logic s, input logic f);
        chk("mode", {14'h0, m}, {14'h0, mode});
        chk("sealed flag", {15'h0, s}, {15'h0, sealed});
        chk("full access flag", {15'h0, f}, {15'h0, full_access_flag});
    endtask : state

    // ********************************
    // scenarios
    // ********************************
    // sealed: info A refused, info B committed only with the right sum
    task automatic t_sealed_info();
        state(MODE_SEALED, 1'b1, 1'b1);
        pfa_host_model_inst.rd(CMD_CTRL_HI, d);
        chk("status sealed bit", 16'h0001, {15'h0, d[5]});
        wr(CMD_BLOCK, INFO_A_SEL);
        wr(8'h40, 8'h5A);
        csum(8'hA5, 1'b0);
        wr(CMD_BLOCK, 8'h02);
        rdc(8'h40, 8'h00);
        wr(8'h40, 8'h5A);
        rdc(CMD_CSUM, 8'hA5);
        csum(8'h00, 1'b0);
        rdc(8'h40, 8'h5A);
        csum(8'hA5, 1'b1);
        wr(CMD_BLOCK, INFO_A_SEL);
        rdc(8'h40, 8'h00);
        wr(CMD_BLOCK, INFO_C_SEL);
        rdc(8'h40, 8'h00);
        wr(CMD_BLOCK, 8'h02);
        rdc(8'h40, 8'h5A);
    endtask : t_sealed_info

    // interrupted key pair is rejected, consecutive pair unlocks
    task automatic t_unlock();
        pfa_host_model_inst.key(KEY_RST[0]);
        ctl(16'h0001);
        pfa_host_model_inst.key(KEY_RST[1]);
        state(MODE_SEALED, 1'b1, 1'b1);
        pfa_host_model_inst.key(KEY_RST[0]);
        pfa_host_model_inst.key(KEY_RST[1]);
        state(MODE_UNLOCKED_MODE, 1'b0, 1'b1);
        ctl(SUBCMD_LOADER);
        state(MODE_UNLOCKED_MODE, 1'b0, 1'b1);
    endtask : t_unlock

    // class access: subclass 58 block 0 is the 32-byte info area, last byte edited
    task automatic t_class();
        wr(CMD_BDC, BDC_CLASS_MODE);
        wr(CMD_CLASS, SUB_INFO);
        wr(CMD_BLOCK, 8'h00);
        rdc(8'h40, 8'h00);
        wr(8'h5F, 8'h77);
        csum(8'h88, 1'b1);
        wr(CMD_BLOCK, 8'h00);
        rdc(8'h5F, 8'h77);
        wr(CMD_CLASS, SUB_KEYS);
        rdc(8'h40, 8'h11);
        rdc(CMD_CSUM, 8'hAB);
        csum(8'hAB, 1'b0);
        wr(CMD_CLASS, SUB_INFO);
        rdc(8'h5F, 8'h77);
        ctl(SUBCMD_SEAL);
        state(MODE_SEALED, 1'b1, 1'b1);
        pfa_host_model_inst.key(KEY_RST[0]);
        pfa_host_model_inst.key(KEY_RST[1]);
        state(MODE_UNLOCKED_MODE, 1'b0, 1'b1);
    endtask : t_class

    // privileged entry, date stamp, then loader where nothing is reachable
    task automatic t_full_loader();
        pfa_host_model_inst.key(KEY_RST[2]);
        pfa_host_model_inst.key(KEY_RST[3]);
        state(MODE_FULL, 1'b0, 1'b0);
        pfa_host_model_inst.rd(CMD_FLAGS_HI, d);
        chk("flags full access bit", 16'h0000, {15'h0, d[6]});
        @(posedge i_ref_clk);
        i_date_wr <= 1'b1;
        i_date    <= '{day: 5'd15, month: 4'd6, year: 16'd2020};
        @(posedge i_ref_clk);
        i_date_wr <= 1'b0;
        wr(CMD_CLASS, SUB_DATA);
        wr(CMD_BLOCK, 8'h00);
        rdc(8'h42, 8'h28);
        rdc(8'h43, 8'hCF);
        // privileged write back only of a block just read, so nothing private is clobbered
        rdc(CMD_CSUM, 8'h08);
        csum(8'h08, 1'b1);
        ctl(SUBCMD_LOADER);
        state(MODE_LOADER, 1'b0, 1'b1);
        rdc(8'h42, 8'h00);
        csum(8'h00, 1'b0);
    endtask : t_full_loader

    // ********************************
    // clock, reset, timeout, sequence
    // ********************************
    initial begin
        i_ref_clk = 1'b0;
        forever begin
            #12.5 i_ref_clk = ~i_ref_clk;
        end
    end

    // whole sequence needs about 135 cycles; a hang is cut short well beyond that
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            end_of_test();
        end
    end

    initial begin
        i_rstn    = 1'b0;
        i_date_wr = 1'b0;
        i_date    = '0;
        repeat (5) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        t_sealed_info();
        t_unlock();
        t_class();
        t_full_loader();
        end_of_test();
    end
endmodule : testbench
